/* File: rtl/csrs_pkg.sv */
// Constants, field layout and phase encoding of the configuration/state readback shifter.
// Assumes one pclk domain; every pin input is synchronised before use.
// Notes on behaviour
// - Rising trigger starts a readback sequence.
// - Valid trigger captures nodes into holding register.
// - With abort enabled, falling trigger aborts readback.
// - Busy output high while sequence runs.
// - Busy rises one clock after valid trigger.
// - Busy falls with the final data bit.
// - After abort, busy holds until termination.
// - Each readback clock rise outputs one bit.
// - Capture control bit low replaces user state by ones.
// - Clock option low selects configuration clock pin.
// - Readback never disturbs running user logic.
// - Requests accepted only while idle after configuration.
// - Capture cell, flip-flop and I/O nodes.
// - Boundary-scan instruction may also start readback.
// - Five dummy bits, frames: zero, data, 1111.
// - User bits inverted, configuration bits not.
// - Abort needs frames plus three clocks, data high.
// - Stream ends with eleven CRC-16 CCITT MSBs.
package csrs_pkg;
  localparam int unsigned FRAMES = 4;
  localparam int unsigned FRAME_DATA_BITS = 8;
  localparam int unsigned CFG_BITS = 16;
  localparam int unsigned USER_BITS = 16;
  localparam int unsigned HOLD_BITS = CFG_BITS + USER_BITS;
  localparam int unsigned USER_FIRST_FRAME = CFG_BITS / FRAME_DATA_BITS;
  localparam int unsigned DUMMY_BITS = 5;
  localparam int unsigned STOP_BITS = 4;
  localparam int unsigned CRC_BITS = 16;
  localparam int unsigned CRC_OUT_BITS = 11;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam int unsigned ABORT_EXTRA = 3;
  localparam int unsigned ABORT_CLOCKS = FRAMES + ABORT_EXTRA;
  localparam int unsigned REARM_GAP = 3;
  localparam int unsigned SYNC_W = 5;
  // APB map
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] CRC_OFF = 8'h08;
  localparam logic [7:0] COUNT_OFF = 8'h0c;
  localparam int unsigned CTRL_ABORT_BIT = 0;
  localparam int unsigned CTRL_CAPTURE_BIT = 1;
  localparam int unsigned CTRL_CLKSRC_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam int unsigned STAT_RIP_BIT = 0;
  localparam int unsigned STAT_ABORTED_BIT = 1;
  localparam int unsigned STAT_CFG_DONE_BIT = 2;
  typedef enum logic [8:0] {
    PH_IDLE  = 9'h001,
    PH_ARM   = 9'h002,
    PH_DUMMY = 9'h004,
    PH_START = 9'h008,
    PH_DATA  = 9'h010,
    PH_STOP  = 9'h020,
    PH_CRC   = 9'h040,
    PH_ABORT = 9'h080,
    PH_COOL  = 9'h100
  } csrs_phase_t;
endpackage

/* File: rtl/csrs_sync.sv */
// Two-flop synchroniser for a group of unrelated level inputs.
// Assumes each bit is a slow level; no bus coherence between bits.
`timescale 1ns/100ps
module csrs_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // csrs_sync

/* File: rtl/csrs_crc.sv */
// Serial CRC-16 CCITT, one bit per step, MSB-first shift.
// Assumes clear and step are never high together.
`timescale 1ns/100ps
module csrs_crc
  import csrs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic step,
  input wire logic din,
  output logic [15:0] crc
);
  logic fb;
  assign fb = din ^ crc[15];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc <= CRC_INIT;
    end else if (clear) begin
      crc <= CRC_INIT;
    end else if (step) begin
      crc <= {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
  end
endmodule // csrs_crc

/* File: rtl/csrs_readback.sv */
// Readback shifter top: captures configuration and user state, streams it serially.
// Assumes APB master on pclk; readback clock, trigger, scan request and done pins are asynchronous.
`timescale 1ns/100ps
module csrs_readback
  import csrs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic readback_clock,
  input wire logic config_clock_pin,
  input wire logic readback_trigger,
  input wire logic scan_readback_request,
  input wire logic config_done,
  input wire logic [CFG_BITS-1:0] config_memory_bits,
  input wire logic [3:0] logic_cell_fgen_out,
  input wire logic [2:0] cell_ff_x_out,
  input wire logic [2:0] cell_ff_y_out,
  input wire logic [1:0] io_output_ff,
  input wire logic [1:0] io_input_first,
  input wire logic [1:0] io_input_second,
  output logic readback_in_progress,
  output logic readback_data
);
  logic [SYNC_W-1:0] sync_q;
  logic rdclk_s, cclk_s, trig_s, scan_s, done_s;
  logic [2:0] ctrl_reg;
  logic abort_enable_option, user_state_capture_option, clock_source_option;
  logic sel_prev_reg, sel_now, rd_rise;
  logic trig_prev_reg, req_prev_reg, req_now, trig_fall;
  csrs_phase_t phase_reg;
  logic [5:0] cnt_reg;
  logic [2:0] frame_reg;
  logic [HOLD_BITS-1:0] hold_reg;
  logic [USER_BITS-1:0] user_nodes;
  logic stream_bit, streaming, crc_clear, crc_step;
  logic [15:0] crc_val;
  logic aborted_reg, abort_evt, abort_clr;
  logic [15:0] crc_last_reg, count_reg;
  logic finish_evt, apb_wr, apb_rd;
  logic [31:0] status_word;

  csrs_sync #(.W(SYNC_W)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({config_done, scan_readback_request, readback_trigger, config_clock_pin, readback_clock}),
    .q(sync_q)
  );
  assign {done_s, scan_s, trig_s, cclk_s, rdclk_s} = sync_q;

  assign abort_enable_option = ctrl_reg[CTRL_ABORT_BIT];
  assign user_state_capture_option = ctrl_reg[CTRL_CAPTURE_BIT];
  assign clock_source_option = ctrl_reg[CTRL_CLKSRC_BIT];

  // Option low picks the configuration clock pin; change it only while idle or edges may be invented
  assign sel_now = clock_source_option ? rdclk_s : cclk_s;
  assign rd_rise = sel_now & ~sel_prev_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_prev_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_now;
    end
  end

  // Trigger judged only at readback clock rises, so width is counted in that clock
  assign req_now = trig_s | scan_s;
  assign trig_fall = trig_prev_reg & ~trig_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev_reg <= 1'b0;
      req_prev_reg <= 1'b0;
    end else if (rd_rise) begin
      trig_prev_reg <= trig_s;
      req_prev_reg <= req_now;
    end
  end

  // Nodes are only sampled, never driven back
  assign user_nodes = {logic_cell_fgen_out, cell_ff_x_out, cell_ff_y_out, io_output_ff,
                       io_input_first, io_input_second};

  assign streaming = (phase_reg == PH_DUMMY) | (phase_reg == PH_START) | (phase_reg == PH_DATA) |
                     (phase_reg == PH_STOP) | (phase_reg == PH_CRC);

  always_comb begin
    unique case (phase_reg)
      PH_START: stream_bit = 1'b0;
      PH_DATA:  stream_bit = hold_reg[0];
      PH_CRC:   stream_bit = crc_val[4'(CRC_BITS - 1) - cnt_reg[3:0]];
      default:  stream_bit = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_IDLE;
      cnt_reg <= 6'h00;
      frame_reg <= 3'h0;
    end else if (rd_rise) begin
      unique case (phase_reg)
        PH_IDLE: begin
          if (done_s && req_now && !req_prev_reg) begin
            phase_reg <= PH_ARM;
          end
        end
        PH_ARM: begin
          phase_reg <= req_now ? PH_DUMMY : PH_IDLE;
          cnt_reg <= 6'h00;
          frame_reg <= 3'h0;
        end
        PH_DUMMY, PH_START, PH_DATA, PH_STOP, PH_CRC: begin
          if (abort_enable_option && trig_fall) begin
            phase_reg <= PH_ABORT;
            cnt_reg <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
            if (phase_reg == PH_DUMMY && cnt_reg == 6'(DUMMY_BITS - 1)) begin
              phase_reg <= PH_START;
              cnt_reg <= 6'h00;
            end else if (phase_reg == PH_START) begin
              phase_reg <= PH_DATA;
              cnt_reg <= 6'h00;
            end else if (phase_reg == PH_DATA && cnt_reg == 6'(FRAME_DATA_BITS - 1)) begin
              phase_reg <= PH_STOP;
              cnt_reg <= 6'h00;
            end else if (phase_reg == PH_STOP && cnt_reg == 6'(STOP_BITS - 1)) begin
              phase_reg <= (frame_reg == 3'(FRAMES - 1)) ? PH_CRC : PH_START;
              frame_reg <= frame_reg + 3'h1;
              cnt_reg <= 6'h00;
            end else if (phase_reg == PH_CRC && cnt_reg == 6'(CRC_OUT_BITS - 1)) begin
              phase_reg <= PH_COOL;
              cnt_reg <= 6'h00;
            end
          end
        end
        PH_ABORT: begin
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == 6'(ABORT_CLOCKS - 1)) begin
            phase_reg <= PH_COOL;
            cnt_reg <= 6'h00;
          end
        end
        PH_COOL: begin
          // Guard gap so a trigger held across the end is not taken as a new request
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == 6'(REARM_GAP - 1)) begin
            phase_reg <= PH_IDLE;
            cnt_reg <= 6'h00;
          end
        end
      endcase
    end
  end

  // Holding register: configuration first, then user state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= '0;
    end else if (rd_rise && phase_reg == PH_ARM && req_now) begin
      hold_reg <= {user_state_capture_option ? ~user_nodes : {USER_BITS{1'b1}},
                   config_memory_bits};
    end else if (rd_rise && phase_reg == PH_DATA) begin
      hold_reg <= {1'b1, hold_reg[HOLD_BITS-1:1]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readback_data <= 1'b1;
    end else if (rd_rise) begin
      if (streaming && !(abort_enable_option && trig_fall)) begin
        readback_data <= stream_bit;
      end else begin
        readback_data <= 1'b1;
      end
    end
  end

  assign finish_evt = rd_rise && ((phase_reg == PH_CRC && cnt_reg == 6'(CRC_OUT_BITS - 1) &&
                      !(abort_enable_option && trig_fall)) ||
                      (phase_reg == PH_ABORT && cnt_reg == 6'(ABORT_CLOCKS - 1)));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readback_in_progress <= 1'b0;
    end else if (rd_rise && phase_reg == PH_ARM && req_now) begin
      readback_in_progress <= 1'b1;
    end else if (finish_evt) begin
      readback_in_progress <= 1'b0;
    end
  end

  assign crc_clear = rd_rise && phase_reg == PH_ARM;
  assign crc_step = rd_rise && streaming && phase_reg != PH_CRC;
  csrs_crc u_crc (
    .clk(pclk),
    .rst_n(presetn),
    .clear(crc_clear),
    .step(crc_step),
    .din(stream_bit),
    .crc(crc_val)
  );

  // APB: access phase answers on its second cycle
  assign apb_wr = psel & penable & pready & pwrite;
  assign apb_rd = psel & penable & ~pready & ~pwrite;
  assign abort_evt = rd_rise && streaming && abort_enable_option && trig_fall;
  assign abort_clr = apb_wr && paddr == STATUS_OFF && pwdata[STAT_ABORTED_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_wr && paddr == CTRL_OFF) begin
      ctrl_reg <= pwdata[2:0];
    end
  end

  // Status bits placed by their field constants, the rest read as zero
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_RIP_BIT] = readback_in_progress;
    status_word[STAT_ABORTED_BIT] = aborted_reg;
    status_word[STAT_CFG_DONE_BIT] = done_s;
  end

  // Set beats clear when both land together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aborted_reg <= 1'b0;
    end else if (abort_evt) begin
      aborted_reg <= 1'b1;
    end else if (abort_clr) begin
      aborted_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_last_reg <= 16'h0000;
      count_reg <= 16'h0000;
    end else if (finish_evt && phase_reg == PH_CRC) begin
      crc_last_reg <= crc_val;
      count_reg <= count_reg + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~(paddr == CTRL_OFF || paddr == STATUS_OFF ||
                 paddr == CRC_OFF || paddr == COUNT_OFF);
      if (apb_rd) begin
        unique case (paddr)
          CTRL_OFF: prdata <= {29'h0, ctrl_reg};
          STATUS_OFF: prdata <= status_word;
          CRC_OFF: prdata <= {16'h0000, crc_last_reg};
          COUNT_OFF: prdata <= {16'h0000, count_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end else if (!psel) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_start;
    rd_rise && phase_reg == PH_IDLE && done_s && req_now && !req_prev_reg |=> phase_reg == PH_ARM;
  endproperty
  a_start: assert property (p_start) else $error("Trigger edge not taken");
  property p_rip_rise;
    rd_rise && phase_reg == PH_ARM && req_now |=> readback_in_progress && phase_reg == PH_DUMMY;
  endproperty
  a_rip_rise: assert property (p_rip_rise) else $error("Busy late after trigger");
  property p_rip_hold;
    streaming || phase_reg == PH_ABORT |-> readback_in_progress;
  endproperty
  a_rip_hold: assert property (p_rip_hold) else $error("Busy dropped mid sequence");
  property p_rip_end;
    rd_rise && phase_reg == PH_CRC && cnt_reg == 6'(CRC_OUT_BITS - 1) && !trig_fall
      |=> !readback_in_progress && readback_data == $past(stream_bit);
  endproperty
  a_rip_end: assert property (p_rip_end) else $error("Busy not dropped with last bit");
  property p_shift;
    rd_rise && streaming && !(abort_enable_option && trig_fall) |=> readback_data == $past(stream_bit);
  endproperty
  a_shift: assert property (p_shift) else $error("Data bit not shifted out");
  property p_abort;
    rd_rise && streaming && abort_enable_option && trig_fall |=> phase_reg == PH_ABORT ##0 aborted_reg;
  endproperty
  a_abort: assert property (p_abort) else $error("Abort not taken");
  property p_abort_high;
    phase_reg == PH_ABORT |-> readback_data && readback_in_progress;
  endproperty
  a_abort_high: assert property (p_abort_high) else $error("Abort tail not high");
  property p_start_bit;
    rd_rise && phase_reg == PH_START && !(abort_enable_option && trig_fall) |=> !readback_data;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("Start bit not zero");
  property p_no_user;
    rd_rise && !user_state_capture_option && phase_reg == PH_DATA && frame_reg >= 3'(USER_FIRST_FRAME)
      |=> readback_data;
  endproperty
  a_no_user: assert property (p_no_user) else $error("User bits leaked");

  property p_busy_low;
    phase_reg == PH_IDLE || phase_reg == PH_ARM || phase_reg == PH_COOL |-> !readback_in_progress;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("Busy high outside sequence");
  property p_capture;
    rd_rise && phase_reg == PH_ARM && req_now
      |=> hold_reg[CFG_BITS-1:0] == $past(config_memory_bits);
  endproperty
  a_capture: assert property (p_capture) else $error("Configuration bits not captured");
  property p_abort_end;
    rd_rise && phase_reg == PH_ABORT && cnt_reg == 6'(ABORT_CLOCKS - 1)
      |=> !readback_in_progress && phase_reg == PH_COOL;
  endproperty
  a_abort_end: assert property (p_abort_end) else $error("Abort tail length wrong");
  // Nothing moves between readback clock rises, so the user side sees a quiet port
  property p_quiet;
    !rd_rise |=> $stable(readback_data) && $stable(hold_reg);
  endproperty
  a_quiet: assert property (p_quiet) else $error("Output moved without clock rise");
  property p_wait_config;
    rd_rise && phase_reg == PH_IDLE && !done_s |=> phase_reg == PH_IDLE;
  endproperty
  a_wait_config: assert property (p_wait_config) else $error("Start before configuration done");

  c_done: cover property (finish_evt && phase_reg == PH_CRC);
  c_abort: cover property (phase_reg == PH_ABORT && finish_evt);
  c_scan: cover property (rd_rise && phase_reg == PH_ARM && scan_s && !trig_s);
  c_refused: cover property (rd_rise && phase_reg == PH_COOL && req_now && !req_prev_reg);
endmodule // csrs_readback

/* File: tb/csrs_partner.sv */
// Far-side controller model: makes the readback clock, drives the trigger, samples data and busy.
// Assumes the bench calls cycle() just after a pclk rising edge; the clock stands still between calls.
`timescale 1ns/100ps
module csrs_partner (
  input wire logic pclk,
  output logic lclk,
  output logic trig,
  input wire logic data,
  input wire logic busy
);
  initial begin
    lclk = 1'b0;
    trig = 1'b0;
  end
  // One period is 8 pclk, 400 ns (2.5 MHz), above the 10 kHz to 1 MHz window
  // Trigger only moves in the low half, so each level stands a full period
  // Sampling 5 pclk after the rise leaves room for the pin synchronisers
  // Single device on this link, never chained
  task automatic cycle(input logic t, output logic d, output logic b);
    lclk <= 1'b1;
    repeat (4) @(posedge pclk);
    lclk <= 1'b0;
    @(posedge pclk);
    d = data;
    b = busy;
    trig <= t;
    repeat (3) @(posedge pclk);
  endtask
endmodule // csrs_partner

/* File: tb/csrs_readback_test.sv */
// Self-checking bench: APB map, normal, refused and aborted readbacks against a computed stream.
// Assumes csrs_pkg, the design files and csrs_partner are compiled first.
`timescale 1ns/100ps
module csrs_readback_test;
  import csrs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, config_done, use_cfg, use_scan;
  logic lclk, trig, rdata, busy, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cfgm, ec;
  logic [3:0] fgen;
  logic [2:0] ffx, ffy;
  logic [1:0] oq, i1, i2;
  logic d_q [0:69];
  logic b_q [0:69];
  logic es [0:67];
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;
  int seed = 32'h6b22;
  csrs_readback csrs_readback_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .readback_clock(use_cfg ? 1'b0 : lclk), .config_clock_pin(use_cfg ? lclk : 1'b0),
    .readback_trigger(use_scan ? 1'b0 : trig), .scan_readback_request(use_scan ? trig : 1'b0),
    .config_done(config_done), .config_memory_bits(cfgm), .logic_cell_fgen_out(fgen), .cell_ff_x_out(ffx),
    .cell_ff_y_out(ffy), .io_output_ff(oq), .io_input_first(i1), .io_input_second(i2),
    .readback_in_progress(busy), .readback_data(rdata));
  csrs_partner csrs_partner_inst (.pclk(pclk), .lclk(lclk), .trig(trig), .data(rdata), .busy(busy));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task print_verdict;
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Trigger high from R0 to R(hi-1); sample i belongs to rise R(i)
  task rec(input int n, input int hi);
    logic dd, bb;
    csrs_partner_inst.cycle(1'b1, dd, bb);
    for (int i = 0; i < n; i++) csrs_partner_inst.cycle(i + 1 < hi, d_q[i], b_q[i]);
  endtask
  // Low trigger with clocking also serves as the post-abort tail and cool-down
  task idle(input int n);
    logic dd, bb;
    repeat (n) csrs_partner_inst.cycle(1'b0, dd, bb);
  endtask
  function automatic void build(input logic cap);
    logic [15:0] u, c;
    logic b;
    int j, f;
    u = cap ? ~{fgen, ffx, ffy, oq, i1, i2} : 16'hffff;
    c = CRC_INIT;
    for (int i = 0; i < 57; i++) begin
      j = (i - 5) % 13;
      f = (i - 5) / 13;
      if (i < 5) b = 1'b1;
      else b = (j == 0) ? 1'b0 : (j > 8) ? 1'b1 : (f < 2) ? cfgm[f * 8 + j - 1] : u[(f - 2) * 8 + j - 1];
      es[i] = b;
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? CRC_POLY : 16'h0000);
    end
    for (int i = 0; i < 11; i++) es[57 + i] = c[15 - i];
    ec = c;
  endfunction
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn, use_cfg, use_scan} = '0;
    {cfgm, fgen, ffx, ffy, oq, i1, i2} = 32'h0;
    config_done = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    chk(rdata, 1'b1);
    chk(busy, 1'b0);
    apb(1'b0, CTRL_OFF, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b0, STATUS_OFF, 32'h0, rd, er);
    chk(rd, 32'h4);
    apb(1'b1, 8'h10, 32'hffffffff, rd, er);
    chk(er, 1'b1);
    // Both clock pins, capture on and off, scan request on the last pass
    for (int k = 0; k < 4; k++) begin
      use_cfg <= k[1];
      use_scan <= (k == 3);
      apb(1'b1, CTRL_OFF, {29'h0, ~k[1], k[0], 1'b0}, rd, er);
      {cfgm, fgen, ffx, ffy, oq, i1, i2} <= $random(seed);
      idle(4);
      build(k[0]);
      rec(70, 70);
      for (int i = 0; i < 70; i++) begin
        chk(b_q[i], i > 0 && i < 69);
        if (i > 1) chk(d_q[i], es[i - 2]);
      end
      rec(4, 4);
      for (int i = 0; i < 4; i++) chk(b_q[i], 1'b0);
      idle(4);
      apb(1'b0, COUNT_OFF, 32'h0, rd, er);
      chk(rd, 32'(k + 1));
      apb(1'b0, CRC_OFF, 32'h0, rd, er);
      chk(rd, {16'h0, ec});
    end
    // Pulse that is gone at the next rise is no valid trigger
    rec(4, 1);
    for (int i = 0; i < 4; i++) chk(b_q[i], 1'b0);
    idle(4);
    config_done <= 1'b0;
    idle(4);
    rec(4, 4);
    for (int i = 0; i < 4; i++) chk(b_q[i], 1'b0);
    config_done <= 1'b1;
    use_cfg <= 1'b0;
    use_scan <= 1'b0;
    idle(4);
    apb(1'b1, CTRL_OFF, 32'h5, rd, er);
    build(1'b0);
    rec(30, 20);
    for (int i = 2; i < 20; i++) chk(d_q[i], es[i - 2]);
    for (int i = 20; i < 28; i++) chk(d_q[i], 1'b1);
    chk(b_q[26], 1'b1);
    chk(b_q[27], 1'b0);
    idle(4);
    apb(1'b0, STATUS_OFF, 32'h0, rd, er);
    chk(rd, 32'h6);
    apb(1'b1, STATUS_OFF, 32'h2, rd, er);
    apb(1'b0, STATUS_OFF, 32'h0, rd, er);
    chk(rd, 32'h4);
    print_verdict();
  end
endmodule // csrs_readback_test
